//--- rtl/pcc_pkg.sv
// Constants, types and register map of the per-channel PCM conditioning block.
// Assumes one 250 MHz system clock and an 8-bit host register port.
// Contract
// - E1 select pair inverts odd or even bits
// - E1 select both ones inverts whole timeslot
// - E1 substitute with first select zero sends idle
// - E1 substitute with first select one sends milliwatt
// - A-law milliwatt repeats its eight fixed bytes
// - mu-law milliwatt repeats its eight fixed bytes
// - E1 signaling source bit needs CAS configured
// - T1 first control bit picks stored signaling
// - T1 second control bit enables robbed-bit insertion
// - SF/SLC96 put C,D in A,B alternately
// - Indirect enable clears on reset, software sets
// - Per-channel enable gates all receive conditioning
// - Busy high during access, falls on tick
// - Indirect access finishes within 640 ns
// - Address write launches access, bit 7 reads
// - Read data lands in buffer within 640 ns
// - Indirect map: control, data trunk, signaling trunk
// - Receive control byte bit layout fixed
// - Test bit sends data to generator or checker
// - Pattern mode zero checks, one overwrites
// - Data trunk replaces output, gates Nx64 clock
// - Signaling trunk nibble replaces signaling output
// - Milliwatt bit sends A-law or mu-law
package pcc_pkg;
	// ==========================================================
	// Register map and reset values
	localparam logic [7:0] REG_CONFIG  = 8'h70;
	localparam logic [7:0] REG_STATUS  = 8'h71;
	localparam logic [7:0] REG_ADDRCTL = 8'h72;
	localparam logic [7:0] REG_DATABUF = 8'h73;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam int         BUSY_BIT    = 7;
	localparam int         RNW_BIT     = 7;
	// Indirect map bases, 0x60 has no entry
	localparam logic [6:0] MAP_CTL_BASE  = 7'h20;
	localparam logic [6:0] MAP_DTRK_BASE = 7'h40;
	localparam logic [6:0] MAP_GAP       = 7'h60;
	// ==========================================================
	// Timing
	localparam int ACC_LIMIT_NS  = 640;
	localparam int CLK_PERIOD_NS = 4;
	localparam int ACC_LIMIT_CYC = ACC_LIMIT_NS / CLK_PERIOD_NS;
	// ==========================================================
	// Data masks and milliwatt tables, bit 1 is the MSB
	localparam logic [7:0] MASK_ODD  = 8'haa;
	localparam logic [7:0] MASK_EVEN = 8'h55;
	localparam logic [7:0] MASK_ALL  = 8'hff;
	localparam logic [7:0] MASK_SIGN = 8'h80;
	localparam logic [7:0] ALAW_MW [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
	                                       8'hb4, 8'ha1, 8'ha1, 8'hb4};
	localparam logic [7:0] ULAW_MW [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
	                                       8'h9e, 8'h8b, 8'h8b, 8'h9e};
	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		PCC_FMT_ESF = 2'h0, PCC_FMT_SF = 2'h1, PCC_FMT_SLC = 2'h2, PCC_FMT_OTHER = 2'h3
	} pcc_fmt_e;
	typedef enum logic [2:0] {
		PCC_IDLE = 3'b001, PCC_RUN = 3'b010, PCC_DONE = 3'b100
	} pcc_acc_e;
	typedef struct packed {
		logic       subst_or_source_ctl;
		logic       select_first_or_insert;
		logic       data_select_second;
		logic       signaling_source_sel;
		logic [3:0] sig_prime;
	} pcc_tx_ctl_s;
	typedef struct packed {
		logic       test_en;
		logic       dtrk_en;
		logic       strk_en;
		logic       mw_en;
		logic       alaw_sel;
		logic       sign_inv;
		logic [1:0] unused;
	} pcc_rx_ctl_s;
endpackage

//--- rtl/pcc_top.sv
// Per-channel PCM conditioning: E1/T1 transmit timeslot manipulation and
// the receive per-channel controller with its indirect register access.
// Assumes all inputs synchronous to sys_clk; per-timeslot control bytes for
// transmit arrive with each timeslot from the transmit controller.
// Indirect storage has no reset; software loads it before enabling channels.
`timescale 1ns/10ps
module pcc_top #(
	parameter int HS_DIV     = 4,
	parameter int ACC_TICKS  = 4,
	parameter int NUM_SLOTS  = 32
) (
	input  wire logic               sys_clk,
	input  wire logic               arst_n,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	output logic [7:0]              reg_rdata,
	input  wire logic               e1_mode,
	input  wire logic               cas_en,
	input  wire pcc_pkg::pcc_fmt_e  tx_format,
	input  wire logic               tx_valid,
	input  wire logic               tx_frame,
	input  wire logic               tx_second_sf,
	input  wire pcc_pkg::pcc_tx_ctl_s tx_ctl,
	input  wire logic [7:0]         tx_idle_code,
	input  wire logic [7:0]         tx_backplane_pcm_in,
	input  wire logic [3:0]         tx_backplane_signaling_in,
	output logic [7:0]              tx_pcm_out,
	output logic [3:0]              tx_sig_out,
	output logic                    tx_sig_insert,
	input  wire logic               nx64_mode,
	input  wire logic               pattern_mode_sel,
	input  wire logic               rx_valid,
	input  wire logic               rx_frame,
	input  wire logic [4:0]         rx_slot,
	input  wire logic [7:0]         rx_pcm_in,
	input  wire logic [7:0]         rx_sig_in,
	input  wire logic [7:0]         rx_prbs_in,
	output logic [7:0]              rx_backplane_pcm_out,
	output logic [7:0]              rx_backplane_signaling_out,
	output logic                    rx_backplane_clk_en,
	output logic                    rx_to_checker,
	output logic                    busy
);
	import pcc_pkg::*;

	// Counter widths hold their terminal counts
	localparam int HW = $clog2(HS_DIV + 1);
	localparam int AW = $clog2(ACC_TICKS + 1);

	// ==========================================================
	// Host registers
	logic [2:0]  config_q;
	logic [7:0]  addrctl_q;
	logic [7:0]  databuf_q;
	logic        per_channel_func_en;
	logic        indirect_access_en;
	logic        launch;

	// Configuration fields
	assign per_channel_func_en = config_q[0];
	assign indirect_access_en  = config_q[1];
	// Launch ignored while indirect mode is off or an access runs
	assign launch = reg_wr && reg_addr == REG_ADDRCTL && indirect_access_en && !busy;

	// Configuration, cleared by reset
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			config_q <= 3'h0;
		end else if (reg_wr && reg_addr == REG_CONFIG) begin
			config_q <= reg_wdata[2:0];
		end
	end

	// Address/control, written whenever addressed
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			addrctl_q <= RST_BYTE;
		end else if (reg_wr && reg_addr == REG_ADDRCTL) begin
			addrctl_q <= reg_wdata;
		end
	end

	// ==========================================================
	// High-speed tick from a divider
	logic [HW-1:0] hs_cnt_q;
	logic          hs_tick;

	// Tick stands in for the internal high-speed clock edge
	assign hs_tick = hs_cnt_q == HW'(HS_DIV - 1);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hs_cnt_q <= '0;
		end else begin
			hs_cnt_q <= hs_tick ? '0 : hs_cnt_q + HW'(1);
		end
	end

	// ==========================================================
	// Indirect access sequencer and storage
	pcc_acc_e      acc_q;
	logic [AW-1:0] acc_cnt_q;
	// Indirect storage, one entry per timeslot
	logic [7:0]    ctl_mem  [NUM_SLOTS];
	logic [7:0]    dtrk_mem [NUM_SLOTS];
	logic [3:0]    strk_mem [NUM_SLOTS];
	logic [6:0]    iaddr;
	logic [4:0]    islot;
	logic [7:0]    iread;

	// Entry index within its 32-entry bank
	assign iaddr = addrctl_q[6:0];
	assign islot = iaddr[4:0];

	// Map decode; the gap and low addresses read as zero
	always_comb begin
		iread = RST_BYTE;
		if (iaddr >= MAP_CTL_BASE && iaddr < MAP_DTRK_BASE) begin
			iread = ctl_mem[islot];
		end else if (iaddr >= MAP_DTRK_BASE && iaddr < MAP_GAP) begin
			iread = dtrk_mem[islot];
		end else if (iaddr > MAP_GAP) begin
			iread = {4'h0, strk_mem[islot]};
		end
	end

	// Busy span is ACC_TICKS plus one tick, well under the limit
	// Launch is refused while busy, so a run never restarts mid-count
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q     <= PCC_IDLE;
			acc_cnt_q <= '0;
		end else begin
			case (acc_q)
				PCC_IDLE: begin
					acc_cnt_q <= '0;
					if (launch) begin
						acc_q <= PCC_RUN;
					end
				end
				PCC_RUN: begin
					if (hs_tick) begin
						acc_cnt_q <= acc_cnt_q + AW'(1);
						if (acc_cnt_q == AW'(ACC_TICKS - 1)) begin
							acc_q <= PCC_DONE;
						end
					end
				end
				PCC_DONE: begin
					if (hs_tick) begin
						acc_q <= PCC_IDLE;
					end
				end
				default: acc_q <= PCC_IDLE;
			endcase
		end
	end

	// Busy falls only on a high-speed tick
	// Launch needs busy low, so set and clear never meet
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
		end else if (launch) begin
			busy <= 1'b1;
		end else if (acc_q == PCC_DONE && hs_tick) begin
			busy <= 1'b0;
		end
	end

	// Data buffer: host writes, completed reads overwrite
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			databuf_q <= RST_BYTE;
		end else if (acc_q == PCC_DONE && hs_tick && addrctl_q[RNW_BIT]) begin
			databuf_q <= iread;
		end else if (reg_wr && reg_addr == REG_DATABUF && !busy) begin
			databuf_q <= reg_wdata;
		end
	end

	// Indirect write commits at the end of the access; no reset, contents undefined
	always_ff @(posedge sys_clk) begin
		if (acc_q == PCC_DONE && hs_tick && !addrctl_q[RNW_BIT]) begin
			if (iaddr >= MAP_CTL_BASE && iaddr < MAP_DTRK_BASE) begin
				ctl_mem[islot] <= databuf_q;
			end else if (iaddr >= MAP_DTRK_BASE && iaddr < MAP_GAP) begin
				dtrk_mem[islot] <= databuf_q;
			end else if (iaddr > MAP_GAP) begin
				strk_mem[islot] <= databuf_q[3:0];
			end
		end
	end

	// Host read mux, registered; unmapped reads give zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CONFIG:  reg_rdata <= {5'h0, config_q};
				REG_STATUS:  reg_rdata <= {busy, 7'h0};
				REG_ADDRCTL: reg_rdata <= addrctl_q;
				REG_DATABUF: reg_rdata <= databuf_q;
				default:     reg_rdata <= RST_BYTE;
			endcase
		end
	end

	// ==========================================================
	// Milliwatt phase counters, one step per frame
	logic [2:0] tx_mw_q;
	logic [2:0] rx_mw_q;

	// Transmit phase steps on each transmit frame pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_mw_q <= 3'h0;
		end else if (tx_frame) begin
			tx_mw_q <= tx_mw_q + 3'h1;
		end
	end

	// Receive phase runs on its own frame pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_mw_q <= 3'h0;
		end else if (rx_frame) begin
			rx_mw_q <= rx_mw_q + 3'h1;
		end
	end

	// ==========================================================
	// Transmit timeslot data
	logic [7:0] tx_data;
	logic [3:0] tx_src;
	logic [3:0] tx_sig;
	logic       tx_ins;
	logic       robbed_fmt;

	// E1 select decode; T1 timeslots pass untouched here
	always_comb begin
		tx_data = tx_backplane_pcm_in;
		if (e1_mode) begin
			case ({tx_ctl.subst_or_source_ctl, tx_ctl.select_first_or_insert,
			       tx_ctl.data_select_second})
				3'b000:  tx_data = tx_backplane_pcm_in;
				3'b001:  tx_data = tx_backplane_pcm_in ^ MASK_ODD;
				3'b010:  tx_data = tx_backplane_pcm_in ^ MASK_EVEN;
				3'b011:  tx_data = tx_backplane_pcm_in ^ MASK_ALL;
				3'b110:  tx_data = ALAW_MW[tx_mw_q];
				3'b111:  tx_data = ULAW_MW[tx_mw_q];
				default: tx_data = tx_idle_code;
			endcase
		end
	end

	// Signaling source and insertion per mode
	assign robbed_fmt = tx_format != PCC_FMT_OTHER;

	always_comb begin
		if (e1_mode) begin
			tx_src = (cas_en && tx_ctl.signaling_source_sel) ? tx_ctl.sig_prime
			                                                 : tx_backplane_signaling_in;
			tx_ins = cas_en;
		end else begin
			tx_src = tx_ctl.subst_or_source_ctl ? tx_ctl.sig_prime
			                                    : tx_backplane_signaling_in;
			tx_ins = tx_ctl.select_first_or_insert && robbed_fmt;
		end
		tx_sig = tx_src;
		// Sixteen-state codes fold C,D onto A,B in SF-type framing
		if (!e1_mode && tx_second_sf && tx_format != PCC_FMT_ESF) begin
			tx_sig = {tx_src[1:0], tx_src[1:0]};
		end
	end

	// Transmit outputs hold between timeslots
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_pcm_out    <= RST_BYTE;
			tx_sig_out    <= 4'h0;
			tx_sig_insert <= 1'b0;
		end else if (tx_valid) begin
			tx_pcm_out    <= tx_data;
			tx_sig_out    <= tx_sig;
			tx_sig_insert <= tx_ins;
		end
	end

	// ==========================================================
	// Receive per-channel conditioning
	pcc_rx_ctl_s rx_ctl;
	logic [7:0]  rx_data;
	logic [7:0]  rx_sig;
	logic        rx_chk;
	logic        rx_gate;

	// Control byte of the channel now on the receive stream
	assign rx_ctl = pcc_rx_ctl_s'(ctl_mem[rx_slot]);

	// Trunk code outranks milliwatt, then test overwrite, then sign flip
	always_comb begin
		rx_data = rx_pcm_in;
		rx_sig  = rx_sig_in;
		rx_chk  = 1'b0;
		rx_gate = 1'b1;
		if (per_channel_func_en) begin
			if (rx_ctl.dtrk_en) begin
				rx_data = dtrk_mem[rx_slot];
				rx_gate = !nx64_mode;
			end else if (rx_ctl.mw_en) begin
				rx_data = rx_ctl.alaw_sel ? ALAW_MW[rx_mw_q] : ULAW_MW[rx_mw_q];
			end else if (rx_ctl.test_en && pattern_mode_sel) begin
				rx_data = rx_prbs_in;
			end else if (rx_ctl.sign_inv) begin
				rx_data = rx_pcm_in ^ MASK_SIGN;
			end
			// Checker still sees the line data, before any overwrite
			rx_chk = rx_ctl.test_en && !pattern_mode_sel;
			if (rx_ctl.strk_en) begin
				rx_sig = {rx_sig_in[7:4], strk_mem[rx_slot]};
			end
		end
	end

	// Receive outputs hold between channels
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_backplane_pcm_out       <= RST_BYTE;
			rx_backplane_signaling_out <= RST_BYTE;
			rx_backplane_clk_en        <= 1'b0;
			rx_to_checker              <= 1'b0;
		end else if (rx_valid) begin
			rx_backplane_pcm_out       <= rx_data;
			rx_backplane_signaling_out <= rx_sig;
			rx_backplane_clk_en        <= rx_gate;
			rx_to_checker              <= rx_chk;
		end
	end

endmodule

//--- verification/pcc_host.sv
// Host model: byte register strobes and polled indirect access sequencing.
// Assumes the block samples the strobes on the rising sys_clk edge.
`timescale 1ns/10ps
module pcc_host (
	input  wire logic       sys_clk,
	input  wire logic       busy,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Write strobe; data inverted once released so stale bytes never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = (a == 8'h70) ? (d & 8'hfb) : d;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b0;
		q = reg_rdata;
	endtask
	// Indirect access: buffer first on writes, launch, then poll busy under a bound
	task automatic acc(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
		output bit to);
		logic [7:0] s;
		if (!a[7])
			wr(8'h73, d);
		wr(8'h72, a);
		@(posedge sys_clk);
		s = 8'h80;
		for (int i = 0; i < 100 && s[7]; i++)
			rd(8'h71, s);
		to = s[7];
		q = 8'h00;
		if (a[7] && !to)
			rd(8'h73, q);
	endtask
endmodule

//--- verification/pcc_props.sv
// Checker for the conditioning block: indirect launch timing and E1/T1 transmit streams.
// Assumes it is bound onto pcc_top and sees only that module's ports.
`timescale 1ns/10ps
module pcc_props #(
	parameter int HS_DIV    = 4,
	parameter int ACC_TICKS = 4
) (
	input wire logic                 sys_clk,
	input wire logic                 arst_n,
	input wire logic                 reg_wr,
	input wire logic [7:0]           reg_addr,
	input wire logic [7:0]           reg_wdata,
	input wire logic                 busy,
	input wire logic                 e1_mode,
	input wire logic                 tx_valid,
	input wire pcc_pkg::pcc_tx_ctl_s tx_ctl,
	input wire logic [7:0]           tx_idle_code,
	input wire logic [7:0]           tx_backplane_pcm_in,
	input wire pcc_pkg::pcc_fmt_e    tx_format,
	input wire logic                 tx_second_sf,
	input wire logic [7:0]           tx_pcm_out,
	input wire logic [3:0]           tx_sig_out,
	input wire logic                 tx_sig_insert
);
	import pcc_pkg::*;
	localparam int LO = ACC_TICKS * HS_DIV;
	localparam int HI = (ACC_TICKS + 1) * HS_DIV;
	logic       acc_en_q;
	logic [7:0] bcnt_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// Helpers: copy of the indirect enable, busy length counter
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_en_q <= 1'b0;
		end else if (reg_wr && reg_addr == REG_CONFIG) begin
			acc_en_q <= reg_wdata[1];
		end
	end
	// Counter saturates so a stuck busy cannot wrap back into range
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			bcnt_q <= 8'h00;
		else if (!busy)
			bcnt_q <= 8'h00;
		else if (bcnt_q != 8'hff)
			bcnt_q <= bcnt_q + 8'h01;
	end
	// ==========================================================
	// Assertions
	launch_busy_a: assert property (
		reg_wr && reg_addr == REG_ADDRCTL && acc_en_q && !busy |=> busy)
		else $error("launch without busy");
	no_launch_a: assert property (
		reg_wr && reg_addr == REG_ADDRCTL && !acc_en_q && !busy |=> !busy)
		else $error("launch while disabled");
	busy_len_a: assert property (
		$fell(busy) |-> bcnt_q >= LO && bcnt_q <= HI) else $error("busy length out of range");
	e1_pass_a: assert property (
		tx_valid && e1_mode && tx_ctl[7:5] == 3'b000 |=> tx_pcm_out == $past(tx_backplane_pcm_in))
		else $error("timeslot not passed");
	odd_inv_a: assert property (
		tx_valid && e1_mode && tx_ctl[7:5] == 3'b001
		|=> tx_pcm_out == ($past(tx_backplane_pcm_in) ^ 8'haa))
		else $error("odd inversion wrong");
	even_inv_a: assert property (
		tx_valid && e1_mode && tx_ctl[7:5] == 3'b010
		|=> tx_pcm_out == ($past(tx_backplane_pcm_in) ^ 8'h55))
		else $error("even inversion wrong");
	all_inv_a: assert property (
		tx_valid && e1_mode && tx_ctl[7:5] == 3'b011 |=> tx_pcm_out == ~$past(tx_backplane_pcm_in))
		else $error("full inversion wrong");
	idle_sub_a: assert property (
		tx_valid && e1_mode && tx_ctl[7:6] == 2'b10 |=> tx_pcm_out == $past(tx_idle_code))
		else $error("idle code not substituted");
	t1_insert_a: assert property (
		tx_valid && !e1_mode
		|=> tx_sig_insert == ($past(tx_ctl[6]) && $past(tx_format) != PCC_FMT_OTHER))
		else $error("insert flag wrong");
	t1_stored_a: assert property (
		tx_valid && !e1_mode && tx_ctl[7] && !tx_second_sf |=> tx_sig_out == $past(tx_ctl[3:0]))
		else $error("stored signaling not used");
	launch_c: cover property (reg_wr && reg_addr == REG_ADDRCTL && acc_en_q && !busy);
	done_c: cover property ($fell(busy));
	mw_c: cover property (tx_valid && e1_mode && tx_ctl[7:6] == 2'b11);
endmodule

bind pcc_top pcc_props #(.HS_DIV(HS_DIV), .ACC_TICKS(ACC_TICKS)) pcc_props_inst (
	.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .busy(busy), .e1_mode(e1_mode), .tx_valid(tx_valid),
	.tx_ctl(tx_ctl), .tx_idle_code(tx_idle_code), .tx_backplane_pcm_in(tx_backplane_pcm_in),
	.tx_format(tx_format), .tx_second_sf(tx_second_sf), .tx_pcm_out(tx_pcm_out),
	.tx_sig_out(tx_sig_out), .tx_sig_insert(tx_sig_insert));

//--- verification/pcc_top_tb.sv
// Testbench for the per-channel conditioning block.
// Assumes the host model owns the register port; the bench drives both streams.
`timescale 1ns/10ps
module pcc_top_tb;
	import pcc_pkg::*;
	logic sys_clk = 1'b0, arst_n = 1'b0, busy, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_pcm_out, rx_pcm_out, rx_sig_out;
	logic e1_mode = 1'b1, cas_en = 1'b1, tx_valid = 1'b0, tx_frame = 1'b0, tx_2sf = 1'b0;
	logic nx64 = 1'b1, pat = 1'b1, rx_valid = 1'b0, rx_frame = 1'b0, clk_en, to_chk, tx_ins;
	logic [3:0] tx_sig = 4'h6, tx_sig_out;
	logic [7:0] tx_pcm = 8'h00, rx_pcm = 8'h00, rx_sig = 8'h02, q;
	pcc_fmt_e tx_format = PCC_FMT_SF;
	pcc_tx_ctl_s tx_ctl = '0;
	int compares = 0, miscompares = 0;
	localparam logic [7:0] AW [8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hb4, 8'ha1, 8'ha1, 8'hb4};
	localparam logic [7:0] MW [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e, 8'h9e, 8'h8b, 8'h8b, 8'h9e};
	always #2 sys_clk = ~sys_clk;
	pcc_host pcc_host_inst (.sys_clk(sys_clk), .busy(busy), .reg_rdata(reg_rdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	pcc_top pcc_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .e1_mode(e1_mode),
		.cas_en(cas_en), .tx_format(tx_format), .tx_valid(tx_valid), .tx_frame(tx_frame),
		.tx_second_sf(tx_2sf), .tx_ctl(tx_ctl), .tx_idle_code(8'h3c),
		.tx_backplane_pcm_in(tx_pcm), .tx_backplane_signaling_in(tx_sig),
		.tx_pcm_out(tx_pcm_out), .tx_sig_out(tx_sig_out), .tx_sig_insert(tx_ins),
		.nx64_mode(nx64), .pattern_mode_sel(pat), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.rx_slot(5'h03), .rx_pcm_in(rx_pcm), .rx_sig_in(rx_sig), .rx_prbs_in(~rx_pcm),
		.rx_backplane_pcm_out(rx_pcm_out), .rx_backplane_signaling_out(rx_sig_out),
		.rx_backplane_clk_en(clk_en), .rx_to_checker(to_chk), .busy(busy));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic acc(input logic [7:0] a, input logic [7:0] d);
		bit to;
		pcc_host_inst.acc(a, d, q, to);
		if (to) begin
			miscompares++;
			give_verdict();
		end
	endtask
	// One timeslot in, conditioned result settled one edge later
	task automatic txs(input logic [7:0] c);
		@(posedge sys_clk);
		#1;
		tx_valid = 1'b1;
		tx_ctl = c;
		tx_pcm = tx_pcm + 8'h35;
		@(posedge sys_clk);
		#1;
		tx_valid = 1'b0;
	endtask
	task automatic rxs();
		@(posedge sys_clk);
		#1;
		rx_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		rx_valid = 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic s_regs();
		for (int a = 8'h70; a < 8'h75; a++) begin
			pcc_host_inst.rd(8'(a), q);
			chk("reset byte", 8'h00, q);
		end
		pcc_host_inst.wr(8'h72, 8'h20);
		pcc_host_inst.rd(8'h71, q);
		chk("busy disabled", 8'h00, q);
		pcc_host_inst.wr(8'h70, 8'h03);
		pcc_host_inst.rd(8'h70, q);
		chk("config", 8'h03, q);
	endtask
	task automatic s_e1();
		txs(8'h00);
		chk("pass", tx_pcm, tx_pcm_out);
		txs(8'h20);
		chk("odd", tx_pcm ^ 8'haa, tx_pcm_out);
		txs(8'h40);
		chk("even", tx_pcm ^ 8'h55, tx_pcm_out);
		txs(8'h60);
		chk("all", ~tx_pcm, tx_pcm_out);
		txs(8'ha0);
		chk("idle", 8'h3c, tx_pcm_out);
		for (int i = 0; i < 16; i++) begin
			txs(i < 8 ? 8'hc0 : 8'he0);
			chk("milliwatt", i < 8 ? AW[i] : MW[i - 8], tx_pcm_out);
			@(posedge sys_clk);
			#1;
			tx_frame = 1'b1;
			@(posedge sys_clk);
			#1;
			tx_frame = 1'b0;
		end
		txs(8'h19);
		chk("e1 stored", 8'h09, {4'h0, tx_sig_out});
		txs(8'h09);
		chk("e1 stream", 8'h06, {4'h0, tx_sig_out});
		cas_en = 1'b0;
		txs(8'h19);
		chk("e1 no cas", 8'h00, {7'h0, tx_ins});
		chk("e1 src ignored", 8'h06, {4'h0, tx_sig_out});
	endtask
	task automatic s_t1();
		e1_mode = 1'b0;
		txs(8'hc9);
		chk("t1 stored", 8'h19, {3'h0, tx_ins, tx_sig_out});
		tx_2sf = 1'b1;
		txs(8'hc9);
		chk("t1 fold stored", 8'h05, {4'h0, tx_sig_out});
		txs(8'h49);
		chk("t1 fold stream", 8'h0a, {4'h0, tx_sig_out});
		tx_2sf = 1'b0;
		txs(8'h49);
		chk("t1 stream", 8'h06, {4'h0, tx_sig_out});
		txs(8'h89);
		chk("t1 off", 8'h00, {7'h0, tx_ins});
		tx_format = PCC_FMT_OTHER;
		txs(8'hc9);
		chk("t1 format", 8'h00, {7'h0, tx_ins});
		tx_2sf = 1'b1;
		tx_format = PCC_FMT_ESF;
		txs(8'hc9);
		chk("esf no fold", 8'h19, {3'h0, tx_ins, tx_sig_out});
		tx_format = PCC_FMT_SLC;
		txs(8'hc9);
		chk("slc fold", 8'h15, {3'h0, tx_ins, tx_sig_out});
	endtask
	task automatic s_rx();
		logic [7:0] cb [5] = '{8'h40, 8'h20, 8'h18, 8'h10, 8'h04};
		logic [7:0] ex [5] = '{8'h5a, 8'h81, 8'h34, 8'h1e, 8'h01};
		acc(8'h43, 8'h5a);
		acc(8'h63, 8'hff);
		acc(8'he3, 8'h00);
		chk("sig trunk byte", 8'h0f, q);
		acc(8'he0, 8'h00);
		chk("gap read", 8'h00, q);
		rx_pcm = 8'h81;
		for (int i = 0; i < 5; i++) begin
			acc(8'h23, cb[i]);
			acc(8'ha3, 8'h00);
			chk("ctl byte", cb[i], q);
			rxs();
			chk("rx pcm", ex[i], rx_pcm_out);
			if (i == 0)
				chk("clk gate", 8'h00, {7'h0, clk_en});
			if (i == 1) begin
				chk("rx sig", 8'h0f, rx_sig_out);
				chk("clk running", 8'h01, {7'h0, clk_en});
				chk("no checker", 8'h00, {7'h0, to_chk});
			end
		end
		// Receive milliwatt phase walks all eight bytes, one per frame
		acc(8'h23, 8'h18);
		for (int j = 0; j < 8; j++) begin
			rxs();
			chk("rx milliwatt", AW[j], rx_pcm_out);
			rx_frame = 1'b1;
			@(posedge sys_clk);
			#1;
			rx_frame = 1'b0;
		end
		acc(8'h23, 8'h80);
		rxs();
		chk("overwrite", 8'h7e, rx_pcm_out);
		pat = 1'b0;
		rxs();
		chk("to checker", 8'h01, {7'h0, to_chk});
		acc(8'h23, 8'h24);
		pcc_host_inst.wr(8'h70, 8'h02);
		rxs();
		chk("disabled", 8'h81, rx_pcm_out);
		chk("disabled sig", 8'h02, rx_sig_out);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		s_regs();
		s_e1();
		s_t1();
		s_rx();
		give_verdict();
	end
endmodule
